// ### logic/sfrm_bank.sv
// register bank, reset-source initialisation and memory spaces
//
// Behaviour
// - pins stay input-only after power-up
// - cause register records latest reset cause
// - watchdog control resets to 1110 01x1
// - timeout flag: 1 watchdog, 0 power-on
// - trim loads factory value on POR/WDT
// - restricted registers only POR/WDT affected
// - extended registers at FFBE-FFE4 via pointer
// - brownout config copied from config byte one
// - clock control loads from config bytes
// - amplifier trims load factory on POR/WDT
// - 128-byte direct data at 00-7F
// - 256-byte indirect data, upper half overlaid
// - registers answer direct and bit accesses, not indirect ones
// - 512-byte auxiliary RAM in external space
// - 64 kB code space, 8 kB on chip
// - bit set, clear, test on bit registers
`timescale 1ns/100ps
module sfrm_bank (
   input wire logic ref_clk,
   input wire logic reset,
   input sfrm_pkg::sfrm_rst_t rst_src,
   input wire logic boi_event,
   input wire logic [7:0] user_cfg1,
   input wire logic [7:0] user_cfg2,
   input wire logic [5:0] factory_trim,
   input wire logic [7:0] factory_amp_lo,
   input wire logic [7:0] factory_amp_hi,
   input wire logic clk_ok,
   input wire logic [7:0] ccu_flag_set,
   input wire logic [2:0] ccu_irq_code,
   input sfrm_pkg::sfrm_req_t req,
   output sfrm_pkg::sfrm_resp_t resp,
   output sfrm_pkg::sfrm_ctl_t ctl,
   output logic [7:0] port0_input_only,
   output logic wd_feed1,
   output logic wd_feed2
);
   import sfrm_pkg::*;

   logic [7:0] indirect_data_space_q [IND_RAM_BYTES];
   logic [7:0] xram_q [XRAM_BYTES];
   logic [7:0] code_q [CODE_BYTES];
   logic [7:0] sfr_q [128];

   logic [7:0] trim_q;
   logic [7:0] wdog_ctrl_q;
   logic [7:0] cause_q;
   logic [7:0] cap_flags_q;
   logic [7:0] rtcl_q;
   logic [7:0] rtch_q;
   logic [7:0] bo_cfg_q;
   logic [7:0] clk_ctrl_q;
   logic [7:0] ampcon_q;
   logic [7:0] ampconb_q;
   logic [7:0] amptrl_q;
   logic [7:0] amptrh_q;
   sfrm_resp_t resp_q;
   logic [7:0] p0_hiz_q;
   logic feed1_q;
   logic feed2_q;

   wire por = reset;
   wire wdt_rst = rst_src.wdt;
   wire other_rst = rst_src.brownout | rst_src.software |
      rst_src.external | rst_src.breakpoint;
   wire any_rst = por | wdt_rst | other_rst;
   wire restricted_rst = por | wdt_rst;

   // mask of bits that exist in each plain direct register
   function automatic logic [7:0] sfr_mask(input logic [7:0] a);
      case (a)
         OFS_PORT0_MODE1, OFS_PORT0_MODE2: sfr_mask = 8'hFF;
         OFS_TMR_CTRL, OFS_TMR_MODE: sfr_mask = 8'hFF;
         OFS_TMR0_LO, OFS_TMR1_LO: sfr_mask = 8'hFF;
         OFS_TMR0_HI, OFS_TMR1_HI: sfr_mask = 8'hFF;
         OFS_WDOG_LOAD, OFS_CAP_CTRL, OFS_CAP_PRE_LO: sfr_mask = 8'hFF;
         OFS_CAP_TMR_LO, OFS_CAP_TMR_HI: sfr_mask = 8'hFF;
         OFS_CAP_RLD_LO, OFS_CAP_RLD_HI: sfr_mask = 8'hFF;
         OFS_CAP_IRQ_EN: sfr_mask = MSK_CCU_IRQ;
         OFS_CAP_PRE_HI: sfr_mask = MSK_CAP_PRE_HI;
         default: sfr_mask = 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] sfr_init(input logic [7:0] a);
      case (a)
         OFS_WDOG_LOAD: sfr_init = RST_WDOG_LOAD;
         OFS_PORT0_MODE1: sfr_init = RST_PORT0_MODE1;
         default: sfr_init = 8'h00;
      endcase
   endfunction

   // request decode
   wire is_bit = req.valid && req.space == SP_BIT;
   wire [7:0] bit_addr = req.addr[7:0];
   wire [2:0] bit_pos = bit_addr[2:0];
   wire [7:0] bit_byte = bit_addr[7] ? {bit_addr[7:3], 3'h0} :
      BIT_RAM_BASE | {4'h0, bit_addr[6:3]};
   wire bit_on_sfr = is_bit && bit_addr[7];
   wire bit_on_ram = is_bit && !bit_addr[7];
   wire bit_modify = is_bit && req.bitop != BOP_TEST;

   wire dir_sfr = req.valid && req.space == SP_DIRECT &&
      req.addr[7];
   wire dir_ram = req.valid && req.space == SP_DIRECT &&
      !req.addr[7];
   wire ind_ram = req.valid && req.space == SP_INDIRECT;
   wire ram_acc = dir_ram | ind_ram | bit_on_ram;
   wire [7:0] ram_addr = bit_on_ram ? bit_byte : req.addr[7:0];

   wire [7:0] sfr_addr = bit_on_sfr ? bit_byte : req.addr[7:0];

   wire xd_ptr = req.valid && req.space == SP_XDPTR;
   wire xd_ri = req.valid && req.space == SP_XRI;
   wire xram_hit = xd_ri ||
      (xd_ptr && req.addr < 16'(XRAM_BYTES));
   wire [8:0] xram_addr = xd_ri ? {1'b0, req.addr[7:0]} :
      req.addr[8:0];
   wire code_acc = req.valid && req.space == SP_CODE;
   wire code_hit = req.addr < 16'(CODE_BYTES);
   wire [12:0] code_addr = req.addr[12:0];

   // current byte under a bit operation, and its modified copy
   logic [7:0] sfr_rd;
   wire [7:0] ram_rd = indirect_data_space_q[ram_addr];
   wire [7:0] bit_src = bit_on_sfr ? sfr_rd : ram_rd;
   wire bit_val = bit_src[bit_pos];
   wire [7:0] bit_one = 8'(1) << bit_pos;
   wire [7:0] bit_new = (req.bitop == BOP_SET) ? (bit_src | bit_one) :
      (bit_src & ~bit_one);

   wire sfr_we = (dir_sfr && req.write) ||
      (bit_on_sfr && bit_modify);
   wire [7:0] sfr_wd = bit_on_sfr ? bit_new : req.wdata;
   wire ram_we = (ram_acc && req.write && !is_bit) ||
      (bit_on_ram && bit_modify);
   wire [7:0] ram_wd = bit_on_ram ? bit_new : req.wdata;

   wire trim_we = sfr_we && sfr_addr == OFS_OSC_TRIM;
   wire wdog_we = sfr_we && sfr_addr == OFS_WDOG_CTRL;
   wire cause_we = sfr_we && sfr_addr == OFS_RSTCAUSE;
   wire cap_flags_we = sfr_we && sfr_addr == OFS_CAP_IRQ_FLAGS;
   wire feed1_we = sfr_we && sfr_addr == OFS_FEED_FIRST;
   wire feed2_we = sfr_we && sfr_addr == OFS_FEED_SECOND;

   wire xw = xd_ptr && req.write;
   wire rtcl_we = xw && req.addr == XOFS_CAL_LO;
   wire rtch_we = xw && req.addr == XOFS_CAL_HI;
   wire bod_we = xw && req.addr == XOFS_BO_CFG;
   wire clk_we = xw && req.addr == XOFS_CLK_CTRL;
   wire ampc_we = xw && req.addr == XOFS_AMPCON;
   wire amplo_we = xw && req.addr == XOFS_AMPTRL;
   wire amphi_we = xw && req.addr == XOFS_AMPTRH;
   wire ampb_we = xw && req.addr == XOFS_AMPCONB;

   // direct register read selection
   always_comb begin
      case (sfr_addr)
         OFS_OSC_TRIM: sfr_rd = trim_q;
         OFS_WDOG_CTRL: sfr_rd = wdog_ctrl_q;
         OFS_RSTCAUSE: sfr_rd = cause_q;
         OFS_CAP_IRQ_FLAGS: sfr_rd = cap_flags_q;
         OFS_CAP_IRQ_CODE: sfr_rd = {5'h00, ccu_irq_code};
         default: sfr_rd = sfr_q[sfr_addr[6:0]];
      endcase
   end

   // extended register read selection, pointer moves only
   logic [7:0] ext_rd;
   always_comb begin
      case (req.addr)
         XOFS_CAL_LO: ext_rd = rtcl_q;
         XOFS_CAL_HI: ext_rd = rtch_q;
         XOFS_BO_CFG: ext_rd = bo_cfg_q;
         XOFS_CLK_CTRL: ext_rd = {clk_ok, clk_ctrl_q[6:0]};
         XOFS_AMPCON: ext_rd = ampcon_q;
         XOFS_AMPTRL: ext_rd = amptrl_q;
         XOFS_AMPTRH: ext_rd = amptrh_q;
         XOFS_AMPCONB: ext_rd = ampconb_q;
         default: ext_rd = EXT_IDLE;
      endcase
   end

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (is_bit)
         rd_mux = {7'h00, bit_val};
      else if (dir_sfr)
         rd_mux = sfr_rd;
      else if (ram_acc)
         rd_mux = ram_rd;
      else if (xram_hit)
         rd_mux = xram_q[xram_addr];
      else if (xd_ptr)
         rd_mux = ext_rd;
      else if (code_acc)
         rd_mux = code_hit ? code_q[code_addr] : CODE_IDLE;
   end

   // plain direct registers, loaded by every reset source: FF in watchdog load and port 0 mode 1, 00 in the rest
   genvar gi;
   generate
      for (gi = 0; gi < 128; gi++) begin : g_sfr
         localparam logic [7:0] ADDR = 8'(128 + gi);
         always_ff @(posedge ref_clk) begin
            if (any_rst)
               sfr_q[gi] <= sfr_init(ADDR);
            else if (sfr_we && sfr_addr == ADDR)
               sfr_q[gi] <= sfr_wd & sfr_mask(ADDR);
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (restricted_rst)
         trim_q <= {2'b00, factory_trim};
      else if (trim_we)
         trim_q <= sfr_wd;
   end

   always_ff @(posedge ref_clk) begin
      if (por)
         wdog_ctrl_q <= RST_WDOG_POR;
      else if (wdt_rst)
         wdog_ctrl_q <= RST_WDOG_WDT;
      else if (wdog_we)
         wdog_ctrl_q <= sfr_wd & MSK_WDOG_CTRL;
   end

   // cause flags; the brownout interrupt flag survives every reset but power-on
   logic [7:0] cause_d;
   always_comb begin
      cause_d = cause_q;
      if (any_rst)
         cause_d = {1'b0, cause_q[CB_BO_IRQ], 6'h00};
      if (rst_src.brownout)
         cause_d[CB_BO_RST] = 1'b1;
      if (rst_src.breakpoint)
         cause_d[CB_BK] = 1'b1;
      if (wdt_rst)
         cause_d[CB_WD] = 1'b1;
      if (rst_src.software)
         cause_d[CB_SF] = 1'b1;
      if (rst_src.external)
         cause_d[CB_EX] = 1'b1;
      if (!any_rst && cause_we)
         cause_d = sfr_wd & MSK_CAUSE;
      if (boi_event)
         cause_d[CB_BO_IRQ] = 1'b1;
      if (por)
         cause_d = RST_CAUSE_POR;
   end

   always_ff @(posedge ref_clk) begin
      cause_q <= cause_d;
   end

   always_ff @(posedge ref_clk) begin
      if (any_rst)
         cap_flags_q <= 8'h00;
      else
         cap_flags_q <= ((cap_flags_we ? sfr_wd : cap_flags_q) |
            ccu_flag_set) & MSK_CCU_IRQ;
   end

   always_ff @(posedge ref_clk) begin
      if (restricted_rst) begin
         rtcl_q <= 8'h00;
         rtch_q <= 8'h00;
      end else begin
         if (rtcl_we)
            rtcl_q <= req.wdata;
         if (rtch_we)
            rtch_q <= req.wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (por)
         bo_cfg_q <= {6'h00, user_cfg1[5], user_cfg1[3]};
      else if (bod_we)
         bo_cfg_q <= req.wdata & MSK_BO_CFG;
   end

   always_ff @(posedge ref_clk) begin
      if (any_rst)
         clk_ctrl_q <= {4'h0, user_cfg2[7], user_cfg1[2:0]};
      else if (clk_we)
         clk_ctrl_q <= req.wdata & MSK_CLK_CTRL;
   end

   always_ff @(posedge ref_clk) begin
      if (restricted_rst) begin
         amptrl_q <= factory_amp_lo;
         amptrh_q <= factory_amp_hi;
      end else begin
         if (amplo_we)
            amptrl_q <= req.wdata;
         if (amphi_we)
            amptrh_q <= req.wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (any_rst) begin
         ampcon_q <= 8'h00;
         ampconb_q <= 8'h00;
      end else begin
         if (ampc_we)
            ampcon_q <= req.wdata & MSK_AMPCON;
         if (ampb_we)
            ampconb_q <= req.wdata & MSK_AMPCONB;
      end
   end

   // memories hold contents across resets
   always_ff @(posedge ref_clk) begin
      if (ram_we)
         indirect_data_space_q[ram_addr] <= ram_wd;
   end

   always_ff @(posedge ref_clk) begin
      if (xram_hit && req.write)
         xram_q[xram_addr] <= req.wdata;
   end

   // code writes are the loader path only
   always_ff @(posedge ref_clk) begin
      if (code_acc && req.write && code_hit)
         code_q[code_addr] <= req.wdata;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         resp_q <= '0;
      end else begin
         resp_q.valid <= req.valid;
         resp_q.rdata <= rd_mux;
      end
   end

   // pins are input-only where mode 1 is set and mode 2 clear
   always_ff @(posedge ref_clk) begin
      if (any_rst)
         p0_hiz_q <= 8'hFF;
      else
         p0_hiz_q <= sfr_q[OFS_PORT0_MODE1[6:0]] &
            ~sfr_q[OFS_PORT0_MODE2[6:0]];
   end

   always_ff @(posedge ref_clk) begin
      if (any_rst) begin
         feed1_q <= 1'b0;
         feed2_q <= 1'b0;
      end else begin
         feed1_q <= feed1_we;
         feed2_q <= feed2_we;
      end
   end

   assign resp = resp_q;
   assign port0_input_only = p0_hiz_q;
   assign wd_feed1 = feed1_q;
   assign wd_feed2 = feed2_q;
   assign ctl.trim = trim_q;
   assign ctl.wdog_ctrl = wdog_ctrl_q;
   assign ctl.wdog_load = sfr_q[OFS_WDOG_LOAD[6:0]];
   assign ctl.clk_ctrl = {clk_ok, clk_ctrl_q[6:0]};
   assign ctl.bo_cfg = bo_cfg_q;
   assign ctl.amp_con = ampcon_q;
   assign ctl.amp_con_b = ampconb_q;
   assign ctl.amp_trim_lo = amptrl_q;
   assign ctl.amp_trim_hi = amptrh_q;
   assign ctl.rtc_data = {rtch_q, rtcl_q};

endmodule // sfrm_bank

// ### shared/sfrm_pkg.sv
// shared constants and types of the register bank and memory map
package sfrm_pkg;

   // direct register offsets
   localparam logic [7:0] OFS_PORT0_MODE1 = 8'h84;
   localparam logic [7:0] OFS_PORT0_MODE2 = 8'h85;
   localparam logic [7:0] OFS_TMR_CTRL = 8'h88;
   localparam logic [7:0] OFS_TMR_MODE = 8'h89;
   localparam logic [7:0] OFS_TMR0_LO = 8'h8A;
   localparam logic [7:0] OFS_TMR1_LO = 8'h8B;
   localparam logic [7:0] OFS_TMR0_HI = 8'h8C;
   localparam logic [7:0] OFS_TMR1_HI = 8'h8D;
   localparam logic [7:0] OFS_OSC_TRIM = 8'h96;
   localparam logic [7:0] OFS_WDOG_CTRL = 8'hA7;
   localparam logic [7:0] OFS_WDOG_LOAD = 8'hC1;
   localparam logic [7:0] OFS_FEED_FIRST = 8'hC2;
   localparam logic [7:0] OFS_FEED_SECOND = 8'hC3;
   localparam logic [7:0] OFS_CAP_CTRL = 8'hC8;
   localparam logic [7:0] OFS_CAP_IRQ_EN = 8'hC9;
   localparam logic [7:0] OFS_CAP_PRE_LO = 8'hCA;
   localparam logic [7:0] OFS_CAP_PRE_HI = 8'hCB;
   localparam logic [7:0] OFS_CAP_TMR_LO = 8'hCC;
   localparam logic [7:0] OFS_CAP_TMR_HI = 8'hCD;
   localparam logic [7:0] OFS_CAP_RLD_LO = 8'hCE;
   localparam logic [7:0] OFS_CAP_RLD_HI = 8'hCF;
   localparam logic [7:0] OFS_CAP_IRQ_CODE = 8'hDE;
   localparam logic [7:0] OFS_RSTCAUSE = 8'hDF;
   localparam logic [7:0] OFS_CAP_IRQ_FLAGS = 8'hE9;

   // extended registers in external data space
   localparam logic [15:0] XOFS_CAL_LO = 16'hFFBE;
   localparam logic [15:0] XOFS_CAL_HI = 16'hFFBF;
   localparam logic [15:0] XOFS_BO_CFG = 16'hFFC8;
   localparam logic [15:0] XOFS_CLK_CTRL = 16'hFFDE;
   localparam logic [15:0] XOFS_AMPCON = 16'hFFE1;
   localparam logic [15:0] XOFS_AMPTRL = 16'hFFE2;
   localparam logic [15:0] XOFS_AMPTRH = 16'hFFE3;
   localparam logic [15:0] XOFS_AMPCONB = 16'hFFE4;

   // memory sizes
   localparam int IND_RAM_BYTES = 256;
   localparam int XRAM_BYTES = 512;
   localparam int CODE_BYTES = 8192;
   localparam logic [7:0] BIT_RAM_BASE = 8'h20;

   // reset and mask values
   localparam logic [7:0] RST_WDOG_POR = 8'hE5;
   localparam logic [7:0] RST_WDOG_WDT = 8'hE7;
   localparam logic [7:0] RST_CAUSE_POR = 8'h30;
   localparam logic [7:0] RST_WDOG_LOAD = 8'hFF;
   localparam logic [7:0] RST_PORT0_MODE1 = 8'hFF;
   localparam logic [7:0] MSK_WDOG_CTRL = 8'hE7;
   localparam logic [7:0] MSK_CAUSE = 8'h7F;
   localparam logic [7:0] MSK_CCU_IRQ = 8'hFB;
   localparam logic [7:0] MSK_CAP_PRE_HI = 8'h03;
   localparam logic [7:0] MSK_BO_CFG = 8'h03;
   localparam logic [7:0] MSK_CLK_CTRL = 8'h1F;
   localparam logic [7:0] MSK_AMPCON = 8'hF3;
   localparam logic [7:0] MSK_AMPCONB = 8'h01;
   localparam logic [7:0] EXT_IDLE = 8'h00;
   localparam logic [7:0] CODE_IDLE = 8'hFF;

   // reset cause bit positions
   localparam int CB_BO_IRQ = 6;
   localparam int CB_BO_RST = 5;
   localparam int CB_PWR_ON = 4;
   localparam int CB_BK = 3;
   localparam int CB_WD = 2;
   localparam int CB_SF = 1;
   localparam int CB_EX = 0;
   localparam int WD_TOF = 1;

   typedef enum logic [2:0] {
      SP_DIRECT, SP_INDIRECT, SP_XDPTR, SP_XRI, SP_CODE, SP_BIT
   } sfrm_space_t;

   typedef enum logic [1:0] {BOP_TEST, BOP_SET, BOP_CLR} sfrm_bitop_t;

   typedef struct packed {
      logic valid;
      sfrm_space_t space;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
      sfrm_bitop_t bitop;
   } sfrm_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
   } sfrm_resp_t;

   typedef struct packed {
      logic wdt;
      logic brownout;
      logic software;
      logic external;
      logic breakpoint;
   } sfrm_rst_t;

   typedef struct packed {
      logic [7:0] trim;
      logic [7:0] wdog_ctrl;
      logic [7:0] wdog_load;
      logic [7:0] clk_ctrl;
      logic [7:0] bo_cfg;
      logic [7:0] amp_con;
      logic [7:0] amp_con_b;
      logic [7:0] amp_trim_lo;
      logic [7:0] amp_trim_hi;
      logic [15:0] rtc_data;
   } sfrm_ctl_t;

endpackage

// ### verification/sfrm_bank_checker.sv
// concurrent assertions on the register bank ports
`timescale 1ns/100ps
module sfrm_bank_checker (
   input wire logic ref_clk,
   input wire logic reset,
   input sfrm_pkg::sfrm_rst_t rst_src,
   input wire logic [7:0] user_cfg1,
   input wire logic [7:0] user_cfg2,
   input wire logic [5:0] factory_trim,
   input wire logic [7:0] factory_amp_lo,
   input wire logic [7:0] factory_amp_hi,
   input sfrm_pkg::sfrm_req_t req,
   input sfrm_pkg::sfrm_resp_t resp,
   input sfrm_pkg::sfrm_ctl_t ctl,
   input wire logic [7:0] port0_input_only
);
   import sfrm_pkg::*;
   sequence por_end;
      $fell(reset);
   endsequence
   sequence wdt_hit;
      rst_src.wdt && !req.valid;
   endsequence
   sequence other_hit;
      (|{rst_src.brownout, rst_src.software, rst_src.external,
         rst_src.breakpoint}) && !rst_src.wdt && !req.valid;
   endsequence
   p0_input_a: assert property (@(posedge ref_clk)
      disable iff (reset) por_end |-> port0_input_only == RST_PORT0_MODE1)
      else $error("port pins not input-only after power-up");
   wdog_por_a: assert property (@(posedge ref_clk)
      disable iff (reset) por_end |-> ctl.wdog_ctrl == RST_WDOG_POR)
      else $error("watchdog control wrong after power-on");
   trim_por_a: assert property (@(posedge ref_clk)
      disable iff (reset) por_end |-> ctl.trim == {2'b00, factory_trim})
      else $error("trim not factory after power-on");
   amp_trim_a: assert property (@(posedge ref_clk)
      disable iff (reset) por_end |-> ctl.amp_trim_lo == factory_amp_lo
      && ctl.amp_trim_hi == factory_amp_hi)
      else $error("amplifier trims not factory after power-on");
   bod_copy_a: assert property (@(posedge ref_clk)
      disable iff (reset)
      por_end |-> ctl.bo_cfg == {6'h00, user_cfg1[5], user_cfg1[3]})
      else $error("brownout config not copied");
   clk_cfg_a: assert property (@(posedge ref_clk)
      disable iff (reset)
      por_end |-> ctl.clk_ctrl[3:0] == {user_cfg2[7], user_cfg1[2:0]})
      else $error("clock control not loaded from config");
   clk_reload_a: assert property (@(posedge ref_clk)
      disable iff (reset)
      other_hit |=> ctl.clk_ctrl[3:0] == {user_cfg2[7], user_cfg1[2:0]})
      else $error("clock control not reloaded by reset");
   wdt_load_a: assert property (@(posedge ref_clk)
      disable iff (reset) wdt_hit |=> ctl.wdog_ctrl == RST_WDOG_WDT
      && ctl.trim == {2'b00, factory_trim})
      else $error("watchdog reset did not reload");
   keep_restricted_a: assert property (@(posedge ref_clk)
      disable iff (reset) other_hit |=> $stable(ctl.trim)
      && $stable(ctl.wdog_ctrl) && $stable(ctl.rtc_data)
      && $stable(ctl.amp_trim_lo) && $stable(ctl.amp_trim_hi))
      else $error("restricted register changed by other reset");
   resp_timing_a: assert property (@(posedge ref_clk)
      disable iff (reset) resp.valid == $past(req.valid))
      else $error("answer not one cycle after request");
endmodule // sfrm_bank_checker

bind sfrm_bank sfrm_bank_checker sfrm_bank_checker_inst (
   .ref_clk(ref_clk), .reset(reset), .rst_src(rst_src),
   .user_cfg1(user_cfg1), .user_cfg2(user_cfg2),
   .factory_trim(factory_trim), .factory_amp_lo(factory_amp_lo),
   .factory_amp_hi(factory_amp_hi), .req(req), .resp(resp), .ctl(ctl),
   .port0_input_only(port0_input_only));

// ### verification/sfrm_core_model.sv
// processor core model issuing register and memory accesses
`timescale 1ns/100ps
module sfrm_core_model (
   input wire logic ref_clk,
   output sfrm_pkg::sfrm_req_t req,
   input sfrm_pkg::sfrm_resp_t resp
);
   import sfrm_pkg::*;
   logic [7:0] rd;
   logic got;
   initial req = '0;
   // extended registers are reached with pointer moves only
   task automatic xfer(input sfrm_space_t s, input logic w,
      input logic [15:0] a, input logic [7:0] d, input sfrm_bitop_t b);
      @(posedge ref_clk);
      #1;
      req = '{1'b1, s, w, a, d, b};
      @(posedge ref_clk);
      #1;
      rd = resp.rdata;
      got = resp.valid;
      // released write, address and data fields stop showing the last value
      req = '{1'b0, s, ~w, ~a, ~d, b};
   endtask
endmodule // sfrm_core_model

// ### verification/tb_top.sv
// self-checking bench of the register bank
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
   fails++; $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module tb_top;
   import sfrm_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   sfrm_rst_t rst_src = '0;
   logic boi_event = 1'b0;
   logic [7:0] user_cfg1 = 8'hAD;
   logic [7:0] user_cfg2 = 8'h80;
   logic [5:0] factory_trim = 6'h2D;
   logic [7:0] factory_amp_lo = 8'h96;
   logic [7:0] factory_amp_hi = 8'h4B;
   logic clk_ok = 1'b1;
   logic [7:0] ccu_flag_set = 8'h00;
   logic [2:0] ccu_irq_code = 3'h5;
   sfrm_req_t req;
   sfrm_resp_t resp;
   sfrm_ctl_t ctl;
   logic [7:0] port0_input_only;
   logic wd_feed1;
   logic wd_feed2;
   int fails = 0;
   int checks_done = 0;
   int cycles = 0;
   always #50 ref_clk = ~ref_clk;
   sfrm_bank sfrm_bank_inst (.ref_clk(ref_clk), .reset(reset),
      .rst_src(rst_src), .boi_event(boi_event), .user_cfg1(user_cfg1),
      .user_cfg2(user_cfg2), .factory_trim(factory_trim),
      .factory_amp_lo(factory_amp_lo), .factory_amp_hi(factory_amp_hi),
      .clk_ok(clk_ok), .ccu_flag_set(ccu_flag_set),
      .ccu_irq_code(ccu_irq_code), .req(req), .resp(resp), .ctl(ctl),
      .port0_input_only(port0_input_only), .wd_feed1(wd_feed1),
      .wd_feed2(wd_feed2));
   sfrm_core_model sfrm_core_model_inst (.ref_clk(ref_clk), .req(req),
      .resp(resp));
   task automatic complete_run();
      $display("mismatches %0d of %0d checks", fails, checks_done);
      if (fails == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         complete_run();
      end
   end
   task automatic wr(sfrm_space_t s, logic [15:0] a, logic [7:0] d);
      sfrm_core_model_inst.xfer(s, 1'b1, a, d, BOP_TEST);
   endtask
   task automatic bop(logic [15:0] a, sfrm_bitop_t b);
      sfrm_core_model_inst.xfer(SP_BIT, b != BOP_TEST, a, 8'h00, b);
   endtask
   task automatic rd(sfrm_space_t s, logic [15:0] a, logic [7:0] e);
      sfrm_core_model_inst.xfer(s, 1'b0, a, 8'h00, BOP_TEST);
      `CHK(sfrm_core_model_inst.got, 1'b1)
      `CHK(sfrm_core_model_inst.rd, e)
   endtask
   task automatic pulse(sfrm_rst_t s);
      @(posedge ref_clk);
      #1 rst_src = s;
      @(posedge ref_clk);
      #1 rst_src = '0;
   endtask
   task automatic t_por();
      @(posedge ref_clk);
      #1 reset = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 reset = 1'b0;
      `CHK(port0_input_only, 8'hFF)
      rd(SP_DIRECT, 16'h00DF, RST_CAUSE_POR);
      rd(SP_DIRECT, 16'h00A7, 8'hE5);
      rd(SP_DIRECT, 16'h0096, {2'b00, factory_trim});
      rd(SP_DIRECT, 16'h00C1, 8'hFF);
      rd(SP_DIRECT, 16'h0089, 8'h00);
      rd(SP_XDPTR, 16'hFFC8, {6'h00, user_cfg1[5], user_cfg1[3]});
      rd(SP_XDPTR, 16'hFFDE, {clk_ok, 3'b000, user_cfg2[7], 3'b101});
      rd(SP_XDPTR, 16'hFFE2, factory_amp_lo);
      rd(SP_XDPTR, 16'hFFE3, factory_amp_hi);
   endtask
   task automatic t_wdt();
      wr(SP_DIRECT, 16'h0096, 8'h5A);
      wr(SP_DIRECT, 16'h00A7, 8'h00);
      wr(SP_DIRECT, 16'h0089, 8'h5A);
      wr(SP_XDPTR, 16'hFFE2, 8'h11);
      pulse(5'b10000);
      rd(SP_DIRECT, 16'h00DF, 8'h04);
      rd(SP_DIRECT, 16'h00A7, 8'hE7);
      rd(SP_DIRECT, 16'h0096, {2'b00, factory_trim});
      rd(SP_DIRECT, 16'h0089, 8'h00);
      rd(SP_XDPTR, 16'hFFE2, factory_amp_lo);
   endtask
   task automatic t_soft();
      logic [4:0] src [4];
      logic [7:0] cb [4];
      src = '{5'b01000, 5'b00100, 5'b00010, 5'b00001};
      cb = '{8'h20, 8'h02, 8'h01, 8'h08};
      @(posedge ref_clk);
      #1 boi_event = 1'b1;
      @(posedge ref_clk);
      #1 boi_event = 1'b0;
      wr(SP_DIRECT, 16'h0096, 8'h1C);
      wr(SP_DIRECT, 16'h00A7, 8'hA2);
      wr(SP_XDPTR, 16'hFFBE, 8'h55);
      wr(SP_XDPTR, 16'hFFE3, 8'h22);
      for (int i = 0; i < 4; i++) begin
         wr(SP_DIRECT, 16'h0089, 8'h5A);
         pulse(src[i]);
         rd(SP_DIRECT, 16'h00DF, 8'h40 | cb[i]);
         rd(SP_DIRECT, 16'h0096, 8'h1C);
         rd(SP_DIRECT, 16'h00A7, 8'hA2);
         rd(SP_XDPTR, 16'hFFBE, 8'h55);
         rd(SP_XDPTR, 16'hFFE3, 8'h22);
         rd(SP_DIRECT, 16'h0089, 8'h00);
      end
   endtask
   task automatic t_spaces();
      wr(SP_DIRECT, 16'h0010, 8'hAA);
      rd(SP_INDIRECT, 16'h0010, 8'hAA);
      wr(SP_INDIRECT, 16'h0089, 8'h33);
      rd(SP_DIRECT, 16'h0089, 8'h00);
      rd(SP_INDIRECT, 16'h0089, 8'h33);
      wr(SP_XRI, 16'h007E, 8'h5A);
      rd(SP_XDPTR, 16'h007E, 8'h5A);
      wr(SP_XDPTR, 16'h01FF, 8'hC3);
      rd(SP_XDPTR, 16'h01FF, 8'hC3);
      wr(SP_CODE, 16'h1FFF, 8'h77);
      rd(SP_CODE, 16'h1FFF, 8'h77);
      rd(SP_CODE, 16'h2000, CODE_IDLE);
      rd(SP_DIRECT, 16'h00FF, 8'h00);
      rd(SP_XDPTR, 16'hFFC0, 8'h00);
      wr(SP_DIRECT, 16'hFFDE, 8'h00);
      rd(SP_XDPTR, 16'hFFDE, {clk_ok, 3'b000, user_cfg2[7], 3'b101});
   endtask
   task automatic t_bits();
      bop(16'h008B, BOP_SET);
      rd(SP_DIRECT, 16'h0088, 8'h08);
      bop(16'h008B, BOP_TEST);
      `CHK(sfrm_core_model_inst.rd[0], 1'b1)
      bop(16'h008B, BOP_CLR);
      rd(SP_DIRECT, 16'h0088, 8'h00);
      bop(16'h00CF, BOP_SET);
      rd(SP_DIRECT, 16'h00C8, 8'h80);
      bop(16'h0009, BOP_SET);
      rd(SP_DIRECT, 16'h0021, 8'h02);
   endtask
   task automatic t_reserved();
      wr(SP_DIRECT, 16'h00CB, 8'hFF);
      rd(SP_DIRECT, 16'h00CB, 8'h03);
      wr(SP_DIRECT, 16'h00C9, 8'hFF);
      rd(SP_DIRECT, 16'h00C9, 8'hFB);
      wr(SP_DIRECT, 16'h00DE, 8'h55);
      rd(SP_DIRECT, 16'h00DE, {5'h00, ccu_irq_code});
      @(posedge ref_clk);
      #1 ccu_flag_set = 8'h05;
      @(posedge ref_clk);
      #1 ccu_flag_set = 8'h00;
      rd(SP_DIRECT, 16'h00E9, 8'h01);
      wr(SP_DIRECT, 16'h00C2, 8'hA5);
      `CHK(wd_feed1, 1'b1)
      wr(SP_DIRECT, 16'h00C3, 8'h5A);
      `CHK(wd_feed2, 1'b1)
      wr(SP_XDPTR, 16'hFFE1, 8'hFF);
      wr(SP_XRI, 16'h00E4, 8'hFF);
      `CHK(ctl.amp_con_b, 8'h00)
      wr(SP_XDPTR, 16'hFFE4, 8'hFF);
      rd(SP_XDPTR, 16'hFFE1, 8'hF3);
      `CHK(ctl.amp_con, 8'hF3)
      `CHK(ctl.amp_con_b, 8'h01)
      wr(SP_XDPTR, 16'hFFBF, 8'hA5);
      `CHK(ctl.rtc_data, 16'hA555)
      wr(SP_DIRECT, 16'h00C1, 8'h3C);
      `CHK(ctl.wdog_load, 8'h3C)
   endtask
   initial begin
      t_por();
      t_wdt();
      t_soft();
      t_spaces();
      t_bits();
      t_reserved();
      t_por();
      complete_run();
   end
endmodule // tb_top
